// ---- bench/ata_cmd_chk.sv ----
// port assertions for the command engine
module ata_cmd_chk
  import ata_cmd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic tf_wr_i,
  input wire logic [2:0] tf_addr_i,
  input wire logic [7:0] tf_wdata_i,
  input wire logic data_wr_i,
  input wire logic [15:0] data_wdata_i,
  input wire logic bsy_o,
  input wire logic drq_o,
  input wire logic intrq_o,
  input wire logic media_wr_o,
  input wire logic [15:0] media_wdata_o,
  input wire logic media_commit_o,
  input wire logic media_done_i,
  input wire logic media_err_i,
  input wire logic nv_health_wr_o,
  input wire logic nv_health_en_o,
  input wire logic health_en_o,
  input wire logic attr_save_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////
  sequence s_wr_start;
    (bsy_o && !drq_o) ##1 (drq_o && !bsy_o && !intrq_o);
  endsequence
  sequence s_finish;
    !bsy_o && !drq_o && intrq_o;
  endsequence
  ////////////////////////////////////////////////////////////
  wr_start_a: assert property (tf_wr_i && !bsy_o && tf_addr_i == TF_CMD && tf_wdata_i == CMD_WRITE_EXT
    |-> ##[1:2] s_wr_start) else $error("write start order wrong");
  bsy_drq_a: assert property (!(bsy_o && drq_o))
    else $error("busy and data request together");
  commit_hold_a: assert property (media_commit_o |-> bsy_o && !drq_o)
    else $error("commit without busy");
  sector_done_a: assert property (bsy_o && media_done_i && !media_err_i |=> !bsy_o && intrq_o)
    else $error("no interrupt after sector");
  sector_err_a: assert property (bsy_o && media_err_i |=> s_finish)
    else $error("write not stopped on error");
  word_pass_a: assert property (drq_o && data_wr_i |=> media_wr_o && media_wdata_o == $past(data_wdata_i))
    else $error("data word not passed on");
  save_walk_a: assert property (attr_save_o |-> bsy_o ##1 bsy_o ##1 s_finish)
    else $error("save sequence wrong");
  nv_store_a: assert property (nv_health_wr_o |-> bsy_o && nv_health_en_o == health_en_o ##1 s_finish)
    else $error("enable state not stored");
endmodule : ata_cmd_chk

bind ata_write_ext_smart_cmd ata_cmd_chk i_chk (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .tf_wr_i(tf_wr_i), .tf_addr_i(tf_addr_i),
  .tf_wdata_i(tf_wdata_i), .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i), .bsy_o(bsy_o),
  .drq_o(drq_o), .intrq_o(intrq_o), .media_wr_o(media_wr_o), .media_wdata_o(media_wdata_o),
  .media_commit_o(media_commit_o), .media_done_i(media_done_i), .media_err_i(media_err_i),
  .nv_health_wr_o(nv_health_wr_o), .nv_health_en_o(nv_health_en_o), .health_en_o(health_en_o),
  .attr_save_o(attr_save_o)
);

// ---- bench/media_model.sv ----
// far-side model: flash store answering commits, and the health sector store
module media_model (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic commit_i,
  input wire logic fail_i,
  input wire logic [3:0] dly_i,
  input wire logic [7:0] addr_i,
  input wire logic thresh_i,
  output logic done_o,
  output logic err_o,
  output logic [15:0] word_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] wait_r;
  // one answer per commit; the delay lets the bench try prompt and slow media
  always_ff @(posedge sys_clk_i) begin
    done_o <= 1'b0;
    err_o <= 1'b0;
    if (sys_rst_i) begin
      wait_r <= 5'h00;
    end else if (commit_i) begin
      wait_r <= {1'b0, dly_i} + 5'h01;
    end else if (wait_r != 5'h00) begin
      wait_r <= wait_r - 5'h01;
      done_o <= (wait_r == 5'h01) && !fail_i;
      err_o <= (wait_r == 5'h01) && fail_i;
    end
  end
  // threshold sector is told apart from data by an inverted upper byte
  assign word_o = {addr_i ^ {8{thresh_i}}, ~addr_i};
endmodule : media_model

// ---- bench/tb_ata_write_ext_smart_cmd.sv ----
// self-checking bench for the extended write and health command engine
module tb_ata_write_ext_smart_cmd
  import ata_cmd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i, sys_rst_i, tf_wr_i, tf_rd_i, ctl_wr_i, data_wr_i, data_rd_i, fail, en;
  logic bsy_o, drq_o, intrq_o, media_wr_o, media_commit_o, media_done_i, media_err_i, attr_save_o;
  logic health_thresh_o, nv_health_en_i, nv_health_wr_o, nv_health_en_o, health_en_o;
  logic [2:0] tf_addr_i;
  logic [3:0] dly;
  logic [7:0] tf_wdata_i, tf_rdata_o, ctl_wdata_i, health_addr_o, spare_pct_i, erase_pct_i;
  logic [15:0] data_wdata_i, data_rdata_o, media_wdata_o, health_word_i;
  logic [47:0] media_lba_o;
  int failures, checked, cycles;
  logic [7:0] feat_t [10] = '{8'hD2, 8'hD2, 8'hD2, 8'hD3, 8'hD4, 8'hD8, 8'hD5, 8'hD9, 8'hDA, 8'hD8};
  logic [7:0] cnt_t [10] = '{8'hF1, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [9:0] ab_t = 10'b01_0100_0100;
  logic [31:0] st_t [4] = '{32'h3232_4FC2, 32'h195A_F42C, 32'h1A02_4FC2, 32'h1A01_F42C};

  ata_write_ext_smart_cmd i_dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .tf_wr_i(tf_wr_i), .tf_rd_i(tf_rd_i),
    .tf_addr_i(tf_addr_i), .tf_wdata_i(tf_wdata_i), .tf_rdata_o(tf_rdata_o), .ctl_wr_i(ctl_wr_i),
    .ctl_wdata_i(ctl_wdata_i), .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i), .data_rd_i(data_rd_i),
    .data_rdata_o(data_rdata_o), .bsy_o(bsy_o), .drq_o(drq_o), .intrq_o(intrq_o), .media_wr_o(media_wr_o),
    .media_wdata_o(media_wdata_o), .media_commit_o(media_commit_o), .media_lba_o(media_lba_o),
    .media_done_i(media_done_i), .media_err_i(media_err_i), .health_addr_o(health_addr_o),
    .health_thresh_o(health_thresh_o), .health_word_i(health_word_i), .spare_pct_i(spare_pct_i),
    .erase_pct_i(erase_pct_i), .nv_health_en_i(nv_health_en_i), .nv_health_wr_o(nv_health_wr_o),
    .nv_health_en_o(nv_health_en_o), .health_en_o(health_en_o), .attr_save_o(attr_save_o)
  );
  media_model i_media (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .commit_i(media_commit_o), .fail_i(fail), .dly_i(dly),
    .addr_i(health_addr_o), .thresh_i(health_thresh_o), .done_o(media_done_i), .err_o(media_err_i),
    .word_o(health_word_i)
  );

  always #5 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // about three times the expected run length
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      end_sim();
    end
  end
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tfw(input logic [2:0] a, input logic [7:0] d);
    tf_addr_i = a;
    tf_wdata_i = d;
    tf_wr_i = 1'b1;
    tick();
    tf_wr_i = 1'b0;
    // strobe stays low across one edge so back-to-back calls never re-drive it in one step
    tick();
  endtask : tfw
  task automatic tfr(input logic [2:0] a, input logic [7:0] e);
    tf_addr_i = a;
    tf_rd_i = 1'b1;
    tick();
    tf_rd_i = 1'b0;
    chk(tf_rdata_o, e);
    tick();
  endtask : tfr
  task automatic hob();
    ctl_wr_i = 1'b1;
    tick();
    ctl_wr_i = 1'b0;
  endtask : hob
  // waits for data request, or for idle with neither flag set
  task automatic wait_on(input logic want);
    int n;
    n = 0;
    while ((want ? drq_o !== 1'b1 : (bsy_o !== 1'b0 || drq_o !== 1'b0)) && n < 200) begin
      tick();
      n++;
    end
    chk({bsy_o, drq_o}, {1'b0, want});
  endtask : wait_on
  task automatic hcmd(input logic [7:0] f, input logic [7:0] c);
    tfw(TF_COUNT, c);
    tfw(TF_LBA_MID, KEY_LO);
    tfw(TF_LBA_HI, KEY_HI);
    tfw(TF_DEV, 8'hF0);
    tfw(TF_FEAT, f);
    tfw(TF_CMD, CMD_HEALTH);
  endtask : hcmd
  task automatic hrun(input logic [7:0] f, input logic [7:0] c, input logic ab);
    hcmd(f, c);
    repeat (4) tick();
    chk(intrq_o, 1'b1);
    tfr(TF_CMD, ab ? 8'h41 : 8'h40);
    tfr(TF_FEAT, ab ? 8'h04 : 8'h00);
  endtask : hrun
  task automatic hread(input logic thr);
    hcmd(thr ? FEAT_READ_THRESH : FEAT_READ_DATA, 8'h00);
    wait_on(1'b1);
    tfr(TF_CMD, 8'h48);
    for (int i = 0; i < 256; i++) begin
      chk(data_rdata_o, {8'(i) ^ {8{thr}}, ~8'(i)});
      data_rd_i = 1'b1;
      tick();
      data_rd_i = 1'b0;
      repeat (2) tick();
    end
    chk(drq_o, 1'b0);
  endtask : hread
  task automatic wcmd(input logic [47:0] l, input logic [15:0] n);
    tfw(TF_COUNT, n[15:8]);
    tfw(TF_COUNT, n[7:0]);
    tfw(TF_LBA_LO, l[31:24]);
    tfw(TF_LBA_LO, l[7:0]);
    tfw(TF_LBA_MID, l[39:32]);
    tfw(TF_LBA_MID, l[15:8]);
    tfw(TF_LBA_HI, l[47:40]);
    tfw(TF_LBA_HI, l[23:16]);
    tfw(TF_DEV, 8'hE0);
    tfw(TF_CMD, CMD_WRITE_EXT);
    wait_on(1'b1);
    chk(intrq_o, 1'b0);
  endtask : wcmd
  task automatic wsec();
    for (int i = 0; i < 256; i++) begin
      data_wdata_i = 16'(i * 3);
      data_wr_i = 1'b1;
      tick();
      data_wr_i = 1'b0;
      tick();
    end
  endtask : wsec
  // failing sector address and residual count, both halves of each field
  task automatic rdback(input logic [47:0] l, input logic [15:0] n);
    chk(intrq_o, 1'b1);
    tfr(TF_CMD, 8'h41);
    tfr(TF_FEAT, 8'h40);
    tfr(TF_LBA_LO, l[7:0]);
    tfr(TF_LBA_MID, l[15:8]);
    tfr(TF_LBA_HI, l[23:16]);
    hob();
    tfr(TF_LBA_LO, l[31:24]);
    hob();
    tfr(TF_LBA_MID, l[39:32]);
    hob();
    tfr(TF_LBA_HI, l[47:40]);
    hob();
    tfr(TF_COUNT, n[15:8]);
    tfr(TF_COUNT, n[7:0]);
  endtask : rdback
  ////////////////////////////////////////////////////////////
  initial begin
    {sys_clk_i, tf_wr_i, tf_rd_i, ctl_wr_i, data_wr_i, data_rd_i, fail} = '0;
    {tf_addr_i, tf_wdata_i, data_wdata_i} = '0;
    sys_rst_i = 1'b1;
    ctl_wdata_i = 8'h80;
    nv_health_en_i = 1'b1;
    en = 1'b1;
    dly = 4'h0;
    spare_pct_i = 8'h32;
    erase_pct_i = 8'h32;
    repeat (20) tick();
    sys_rst_i = 1'b0;
    repeat (2) tick();
    chk(health_en_o, 1'b1);
    chk({bsy_o, drq_o}, 2'b00);
    for (int i = 0; i < 10; i++) begin
      hrun(feat_t[i], cnt_t[i], ab_t[i]);
      en = (feat_t[i] == FEAT_DISABLE) ? 1'b0 : (feat_t[i] == FEAT_ENABLE) ? 1'b1 : en;
      chk(health_en_o, en);
    end
    $display("test health sub-operations done");
    for (int i = 0; i < 4; i++) begin
      {spare_pct_i, erase_pct_i} = st_t[i][31:16];
      hrun(FEAT_STATUS, 8'h00, 1'b0);
      tfr(TF_LBA_MID, st_t[i][15:8]);
      tfr(TF_LBA_HI, st_t[i][7:0]);
    end
    $display("test return status done");
    hread(1'b0);
    hread(1'b1);
    $display("test health reads done");
    wcmd(48'h1234_5678_9ABC, 16'h0002);
    wsec();
    chk(media_lba_o, 48'h1234_5678_9ABC);
    wait_on(1'b1);
    chk(intrq_o, 1'b1);
    chk(media_lba_o, 48'h1234_5678_9ABD);
    tfr(TF_CMD, 8'h48);
    fail = 1'b1;
    dly = 4'h7;
    wsec();
    wait_on(1'b0);
    rdback(48'h1234_5678_9ABD, 16'h0001);
    $display("test write with error done");
    fail = 1'b0;
    wcmd(48'h0000_0000_0010, 16'h0000);
    wsec();
    wait_on(1'b1);
    fail = 1'b1;
    wsec();
    wait_on(1'b0);
    rdback(48'h0000_0000_0011, 16'hFFFF);
    $display("test full-length count done");
    end_sim();
  end
endmodule : tb_ata_write_ext_smart_cmd

// ---- src/ata_cmd_pkg.sv ----
// constants for the extended write and health-monitoring command handler
package ata_cmd_pkg;

  // command codes
  localparam logic [7:0] CMD_WRITE_EXT = 8'h34;
  localparam logic [7:0] CMD_HEALTH = 8'hB0;

  // health sub-operations, selected by the feature byte
  localparam logic [7:0] FEAT_READ_DATA = 8'hD0;
  localparam logic [7:0] FEAT_READ_THRESH = 8'hD1;
  localparam logic [7:0] FEAT_AUTOSAVE = 8'hD2;
  localparam logic [7:0] FEAT_SAVE = 8'hD3;
  localparam logic [7:0] FEAT_OFFLINE = 8'hD4;
  localparam logic [7:0] FEAT_ENABLE = 8'hD8;
  localparam logic [7:0] FEAT_DISABLE = 8'hD9;
  localparam logic [7:0] FEAT_STATUS = 8'hDA;

  // access key, return-status answers and autosave control values
  localparam logic [7:0] KEY_HI = 8'hC2;
  localparam logic [7:0] KEY_LO = 8'h4F;
  localparam logic [7:0] EXCEED_HI = 8'h2C;
  localparam logic [7:0] EXCEED_LO = 8'hF4;
  localparam logic [7:0] AUTOSAVE_ON = 8'hF1;
  localparam logic [7:0] AUTOSAVE_OFF = 8'h00;

  // task file addresses
  localparam logic [2:0] TF_FEAT = 3'h1;
  localparam logic [2:0] TF_COUNT = 3'h2;
  localparam logic [2:0] TF_LBA_LO = 3'h3;
  localparam logic [2:0] TF_LBA_MID = 3'h4;
  localparam logic [2:0] TF_LBA_HI = 3'h5;
  localparam logic [2:0] TF_DEV = 3'h6;
  localparam logic [2:0] TF_CMD = 3'h7;

  // bit positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_MEDIA = 6;
  localparam int ER_ABRT = 2;
  localparam int CTL_HOB = 7;
  localparam int DEV_SEL = 4;

  // transfer sizes and limits
  localparam int SECTOR_WORDS = 256;
  localparam logic [16:0] MAX_SECTORS = 17'h1_0000;
  localparam logic [7:0] SPARE_LIMIT_PCT = 8'h19;
  localparam logic [7:0] ERASE_LIMIT_PCT = 8'h01;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ACCEPT = 3'b001,
    S_WR_DRQ = 3'b010,
    S_WR_COMMIT = 3'b011,
    S_RD_DRQ = 3'b100,
    S_SAVE = 3'b101,
    S_FINISH = 3'b110
  } cmd_state_e;

endpackage : ata_cmd_pkg

// ---- src/ata_write_ext_smart_cmd.sv ----
// task file, extended sector write and health-monitoring command engine
//
// Overview of operation
// - command 34h is taken as the 48-bit-address sector write
// - the extended write moves 1 to 65,536 sectors from the 16-bit count
// - a count of 0000h means 65,536 sectors
// - every data-request block after the first raises an interrupt
// - on a media error writing stops; the 48-bit failing address is loaded back
// - each 16-bit field is written twice: earlier write is the upper half
// - feature byte picks the health sub-operation D0h..DAh
// - unsupported feature values end in an aborted command
// - D8h/D9h enable or disable health access; the state is kept non-volatile
// - return status flags exceeded spare or erase-count limits
// - exceeded: cylinder low F4h, cylinder high 2Ch
// - not exceeded: cylinder low 4Fh, cylinder high C2h
// - autosave control takes F1h or 00h and completes as a no-op
// - save values: busy, commit attributes, clear busy, interrupt
// - offline immediate completes with no data collection
// - read data returns exactly one sector
// - high-order-byte bit selects the upper half; any task file access clears it
// - on a write, busy then data-request, no interrupt before first sector
module ata_write_ext_smart_cmd
  import ata_cmd_pkg::*;
#(
  parameter logic [7:0] SPARE_LIMIT = SPARE_LIMIT_PCT,
  parameter logic [7:0] ERASE_LIMIT = ERASE_LIMIT_PCT
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic tf_wr_i,
  input wire logic tf_rd_i,
  input wire logic [2:0] tf_addr_i,
  input wire logic [7:0] tf_wdata_i,
  output logic [7:0] tf_rdata_o,
  input wire logic ctl_wr_i,
  input wire logic [7:0] ctl_wdata_i,
  input wire logic data_wr_i,
  input wire logic [15:0] data_wdata_i,
  input wire logic data_rd_i,
  output logic [15:0] data_rdata_o,
  output logic bsy_o,
  output logic drq_o,
  output logic intrq_o,
  output logic media_wr_o,
  output logic [15:0] media_wdata_o,
  output logic media_commit_o,
  output logic [47:0] media_lba_o,
  input wire logic media_done_i,
  input wire logic media_err_i,
  output logic [7:0] health_addr_o,
  output logic health_thresh_o,
  input wire logic [15:0] health_word_i,
  input wire logic [7:0] spare_pct_i,
  input wire logic [7:0] erase_pct_i,
  input wire logic nv_health_en_i,
  output logic nv_health_wr_o,
  output logic nv_health_en_o,
  output logic health_en_o,
  output logic attr_save_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [16:0] sector_total(input logic [7:0] hi, input logic [7:0] lo);
    sector_total = ({hi, lo} == 16'h0000) ? MAX_SECTORS : {1'b0, hi, lo};
  endfunction : sector_total
  function automatic logic limit_hit(input logic [7:0] spare, input logic [7:0] erase);
    limit_hit = (spare <= SPARE_LIMIT) || (erase <= ERASE_LIMIT);
  endfunction : limit_hit

  ////////////////////////////////////////////////////////////////////////////
  // state
  cmd_state_e state_r, state_nxt;
  logic [7:0] cur_r [1:5];
  logic [7:0] prev_r [1:5];
  logic [7:0] dev_r, err_r, feat_r;
  logic err_flag_r, hob_r, intrq_r, health_en_r, nv_loaded_r;
  logic [47:0] lba_r;
  logic [16:0] rem_r;
  logic cmd_wr, host_wr, do_abort, do_finish, do_status, do_fail, set_irq;
  logic key_ok, sect_last, wr_step, rd_step;
  logic [7:0] word_idx;
  assign host_wr = tf_wr_i && !bsy_o;
  assign cmd_wr = host_wr && (tf_addr_i == TF_CMD);
  assign key_ok = (cur_r[TF_LBA_HI] == KEY_HI) && (cur_r[TF_LBA_MID] == KEY_LO) && dev_r[DEV_SEL];
  assign wr_step = data_wr_i && (state_r == S_WR_DRQ);
  assign rd_step = data_rd_i && (state_r == S_RD_DRQ);
  assign bsy_o = (state_r == S_ACCEPT) || (state_r == S_WR_COMMIT) || (state_r == S_SAVE) || (state_r == S_FINISH);
  assign drq_o = (state_r == S_WR_DRQ) || (state_r == S_RD_DRQ);
  assign intrq_o = intrq_r;
  assign health_en_o = health_en_r;
  assign health_addr_o = word_idx;
  assign health_thresh_o = (feat_r == FEAT_READ_THRESH);
  assign media_lba_o = lba_r;

  word_counter #(.WORDS(SECTOR_WORDS)) u_words (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(state_r == S_IDLE),
    .step_i(wr_step || rd_step),
    .idx_o(word_idx),
    .last_o(sect_last)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command decode and sequencing
  always_comb begin
    state_nxt = state_r;
    do_abort = 1'b0;
    do_finish = 1'b0;
    do_status = 1'b0;
    do_fail = 1'b0;
    set_irq = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (cmd_wr) begin
          case (tf_wdata_i)
            CMD_WRITE_EXT: state_nxt = S_ACCEPT;
            CMD_HEALTH: begin
              if (!key_ok || (!health_en_r && cur_r[TF_FEAT] != FEAT_ENABLE)) begin
                do_abort = 1'b1;
              end else begin
                case (cur_r[TF_FEAT])
                  FEAT_READ_DATA, FEAT_READ_THRESH: begin
                    state_nxt = S_RD_DRQ;
                    set_irq = 1'b1;
                  end
                  FEAT_SAVE: state_nxt = S_SAVE;
                  FEAT_STATUS: begin
                    do_status = 1'b1;
                    do_finish = 1'b1;
                  end
                  FEAT_ENABLE, FEAT_DISABLE, FEAT_OFFLINE: do_finish = 1'b1;
                  FEAT_AUTOSAVE: begin
                    // attribute data is always current, so either value is a no-op
                    if (cur_r[TF_COUNT] == AUTOSAVE_ON || cur_r[TF_COUNT] == AUTOSAVE_OFF) begin
                      do_finish = 1'b1;
                    end else begin
                      do_abort = 1'b1;
                    end
                  end
                  default: do_abort = 1'b1;
                endcase
              end
            end
            default: do_abort = 1'b1;
          endcase
          if (do_finish) begin
            state_nxt = S_FINISH;
          end
        end
      end
      S_ACCEPT: state_nxt = S_WR_DRQ;
      S_WR_DRQ: begin
        if (sect_last) begin
          state_nxt = S_WR_COMMIT;
        end
      end
      S_WR_COMMIT: begin
        if (media_err_i) begin
          do_fail = 1'b1;
          set_irq = 1'b1;
          state_nxt = S_IDLE;
        end else if (media_done_i) begin
          set_irq = 1'b1;
          state_nxt = (rem_r == 17'h0_0001) ? S_IDLE : S_WR_DRQ;
        end
      end
      S_RD_DRQ: begin
        if (sect_last) begin
          state_nxt = S_IDLE;
        end
      end
      S_SAVE: state_nxt = S_FINISH;
      S_FINISH: begin
        set_irq = 1'b1;
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      feat_r <= 8'h00;
    end else if (cmd_wr) begin
      feat_r <= cur_r[TF_FEAT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write transfer bookkeeping and health read data capture
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      lba_r <= 48'h0000_0000_0000;
      rem_r <= 17'h0_0000;
    end else if (cmd_wr && tf_wdata_i == CMD_WRITE_EXT) begin
      lba_r <= {prev_r[TF_LBA_HI], prev_r[TF_LBA_MID], prev_r[TF_LBA_LO],
                cur_r[TF_LBA_HI], cur_r[TF_LBA_MID], cur_r[TF_LBA_LO]};
      rem_r <= sector_total(prev_r[TF_COUNT], cur_r[TF_COUNT]);
    end else if (state_r == S_WR_COMMIT && media_done_i && !media_err_i) begin
      lba_r <= lba_r + 48'h0000_0000_0001;
      rem_r <= rem_r - 17'h0_0001;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      media_wr_o <= 1'b0;
      media_wdata_o <= 16'h0000;
      media_commit_o <= 1'b0;
    end else begin
      media_wr_o <= wr_step;
      media_commit_o <= (state_r == S_WR_DRQ) && sect_last;
      if (wr_step) begin
        media_wdata_o <= data_wdata_i;
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      data_rdata_o <= 16'h0000;
    end else if (state_r == S_RD_DRQ) begin
      data_rdata_o <= health_word_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // task file registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 1; i <= 5; i++) begin
        cur_r[i] <= 8'h00;
        prev_r[i] <= 8'h00;
      end
      dev_r <= 8'h00;
    end else if (do_fail) begin
      // failing sector address and residual count for the host to read back
      cur_r[TF_LBA_LO] <= lba_r[7:0];
      cur_r[TF_LBA_MID] <= lba_r[15:8];
      cur_r[TF_LBA_HI] <= lba_r[23:16];
      prev_r[TF_LBA_LO] <= lba_r[31:24];
      prev_r[TF_LBA_MID] <= lba_r[39:32];
      prev_r[TF_LBA_HI] <= lba_r[47:40];
      cur_r[TF_COUNT] <= rem_r[7:0];
      prev_r[TF_COUNT] <= rem_r[15:8];
    end else if (do_status) begin
      if (limit_hit(spare_pct_i, erase_pct_i)) begin
        cur_r[TF_LBA_MID] <= EXCEED_LO;
        cur_r[TF_LBA_HI] <= EXCEED_HI;
      end else begin
        cur_r[TF_LBA_MID] <= KEY_LO;
        cur_r[TF_LBA_HI] <= KEY_HI;
      end
    end else if (host_wr) begin
      if (tf_addr_i == TF_DEV) begin
        dev_r <= tf_wdata_i;
      end else if (tf_addr_i >= TF_FEAT && tf_addr_i <= TF_LBA_HI) begin
        // the older byte slides into the upper half
        prev_r[tf_addr_i] <= cur_r[tf_addr_i];
        cur_r[tf_addr_i] <= tf_wdata_i;
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hob_r <= 1'b0;
    end else if (ctl_wr_i) begin
      hob_r <= ctl_wdata_i[CTL_HOB];
    end else if (tf_rd_i || tf_wr_i) begin
      hob_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tf_rdata_o <= 8'h00;
    end else if (tf_rd_i) begin
      case (tf_addr_i)
        TF_FEAT: tf_rdata_o <= err_r;
        TF_COUNT, TF_LBA_LO, TF_LBA_MID, TF_LBA_HI: begin
          tf_rdata_o <= hob_r ? prev_r[tf_addr_i] : cur_r[tf_addr_i];
        end
        TF_DEV: tf_rdata_o <= dev_r;
        TF_CMD: begin
          tf_rdata_o <= '0;
          tf_rdata_o[ST_BSY] <= bsy_o;
          tf_rdata_o[ST_DRDY] <= !bsy_o;
          tf_rdata_o[ST_DRQ] <= drq_o;
          tf_rdata_o[ST_ERR] <= err_flag_r;
        end
        default: tf_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error, interrupt and completion flags
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      err_r <= 8'h00;
      err_flag_r <= 1'b0;
    end else if (do_abort) begin
      err_r <= 8'h00;
      err_r[ER_ABRT] <= 1'b1;
      err_flag_r <= 1'b1;
    end else if (do_fail) begin
      err_r <= 8'h00;
      err_r[ER_MEDIA] <= 1'b1;
      err_flag_r <= 1'b1;
    end else if (cmd_wr) begin
      err_r <= 8'h00;
      err_flag_r <= 1'b0;
    end
  end
  // an abort completes at once; other completions arrive via set_irq
  // status read clears the request, but a new event in that cycle wins
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      intrq_r <= 1'b0;
    end else if (set_irq || do_abort) begin
      intrq_r <= 1'b1;
    end else if ((tf_rd_i && tf_addr_i == TF_CMD) || cmd_wr) begin
      intrq_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      attr_save_o <= 1'b0;
    end else begin
      attr_save_o <= (state_nxt == S_SAVE) && (state_r == S_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // non-volatile health enable
  // the stored value is caught one clock after reset release, never under reset
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      nv_loaded_r <= 1'b0;
      health_en_r <= 1'b0;
      nv_health_wr_o <= 1'b0;
      nv_health_en_o <= 1'b0;
    end else begin
      nv_loaded_r <= 1'b1;
      nv_health_wr_o <= 1'b0;
      if (!nv_loaded_r) begin
        health_en_r <= nv_health_en_i;
      end else if (do_finish && cur_r[TF_FEAT] == FEAT_ENABLE) begin
        health_en_r <= 1'b1;
        nv_health_wr_o <= 1'b1;
        nv_health_en_o <= 1'b1;
      end else if (do_finish && cur_r[TF_FEAT] == FEAT_DISABLE) begin
        health_en_r <= 1'b0;
        nv_health_wr_o <= 1'b1;
        nv_health_en_o <= 1'b0;
      end
    end
  end

endmodule : ata_write_ext_smart_cmd

// ---- src/word_counter.sv ----
// counts the 16-bit words of one sector and flags the last one
module word_counter
  import ata_cmd_pkg::*;
#(
  parameter int WORDS = SECTOR_WORDS
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic clr_i,
  input wire logic step_i,
  output logic [$clog2(WORDS)-1:0] idx_o,
  output logic last_o
);

  localparam logic [$clog2(WORDS)-1:0] LAST_IDX = ($clog2(WORDS))'(WORDS - 1);

  assign last_o = step_i && (idx_o == LAST_IDX);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || clr_i || last_o) begin
      idx_o <= '0;
    end else if (step_i) begin
      idx_o <= idx_o + 1'b1;
    end
  end

endmodule : word_counter
